// *** rtl/adc_out_pkg.sv ***
// Constants, field positions and types shared by the converter output block
package adc_out_pkg;

  // Widths and channel count
  localparam int NUM_CH = 2;
  localparam int WORD_W = 12;
  localparam int RAW_W = 14;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Sample latency in conversion-clock cycles
  localparam int PIPE_DEPTH = 8;

  // Timing: clock period and power-down float/drive delay
  localparam int CLK_PERIOD_NS = 10;
  localparam int PD_FLOAT_NS = 10;
  localparam int PD_FLOAT_CYC = (PD_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PD_FLOAT_LOAD = 4'(PD_FLOAT_CYC - 1);

  // Quantizer span and output codes
  localparam logic signed [RAW_W-1:0] RAW_MAX = 14'sh07ff;
  localparam logic signed [RAW_W-1:0] RAW_MIN = 14'sh3800;
  localparam logic [WORD_W-1:0] FS_POS = 12'h7ff;
  localparam logic [WORD_W-1:0] FS_NEG = 12'h800;
  localparam logic [WORD_W-1:0] MSB_FLIP = 12'h800;
  localparam logic [WORD_W-1:0] GRAY_MID = 12'hc00;

  // Synchronised pin positions
  localparam int PIN_HALF = 0;
  localparam int PIN_QUARTER = 1;
  localparam int PIN_GRAY = 2;
  localparam int PIN_PD = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] MASK_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] STATE_OFS = 12'h00c;

  // Register fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_RANGE_A = 0;
  localparam int ST_RANGE_B = 1;
  localparam int ST_FLOAT = 2;
  localparam int ST_BAD_DIV = 3;
  localparam int STATUS_W = 4;
  localparam logic [STATUS_W-1:0] STATUS_RST = 4'h0;
  localparam logic [STATUS_W-1:0] MASK_RST = 4'h0;
  localparam int STATE_PWR_LSB = 0;
  localparam int STATE_RATE_LSB = 4;
  localparam int STATE_GRAY_BIT = 7;
  localparam int STATE_FLOAT_BIT = 8;

  // Sample rate; the code equals the half-period of the strobe in clocks
  typedef enum logic [2:0] {
    RATE_FULL = 3'b001,
    RATE_HALF = 3'b010,
    RATE_QUARTER = 3'b100
  } rate_e;

  // Output driver state
  typedef enum logic [3:0] {
    PWR_RUN = 4'b0001,
    PWR_FLOAT_WAIT = 4'b0010,
    PWR_FLOAT = 4'b0100,
    PWR_WAKE_WAIT = 4'b1000
  } pwr_state_e;

endpackage

// *** rtl/coder_if.sv ***
// Raw samples in, coded words and range flags out, between top and coder
`timescale 1ns/1ns
interface coder_if;
  logic signed [adc_out_pkg::RAW_W-1:0] raw [adc_out_pkg::NUM_CH];
  logic gray;
  logic [adc_out_pkg::WORD_W-1:0] word [adc_out_pkg::NUM_CH];
  logic [adc_out_pkg::NUM_CH-1:0] flag;

  modport enc (input raw, input gray, output word, output flag);
  modport user (output raw, output gray, input word, input flag);
endinterface

// *** rtl/sample_coder.sv ***
// Clamps each raw sample to the 12-bit span and codes it
`timescale 1ns/1ns
module sample_coder (
  // Samples in, codes out
  coder_if.enc cif
);

  for (genvar ch = 0; ch < adc_out_pkg::NUM_CH; ch++) begin : g_ch
    logic over;
    logic under;
    logic [adc_out_pkg::WORD_W-1:0] tc;
    logic [adc_out_pkg::WORD_W-1:0] ob;

    assign over = $signed(cif.raw[ch]) > adc_out_pkg::RAW_MAX;
    assign under = $signed(cif.raw[ch]) < adc_out_pkg::RAW_MIN;
    assign cif.flag[ch] = over | under;

    assign tc = over ? adc_out_pkg::FS_POS :
                under ? adc_out_pkg::FS_NEG : cif.raw[ch][adc_out_pkg::WORD_W-1:0];

    assign ob = tc ^ adc_out_pkg::MSB_FLIP;

    assign cif.word[ch] = cif.gray ? (ob ^ (ob >> 1)) : tc;
  end

endmodule

// *** rtl/adc_output_top.sv ***
// Output side of a dual 12-bit converter: rate divider, strobe, coding, float
`timescale 1ns/1ns
module adc_output_top (
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Quantizer results on this clock
  input wire logic signed [adc_out_pkg::RAW_W-1:0] raw_sample_a,
  input wire logic signed [adc_out_pkg::RAW_W-1:0] raw_sample_b,
  // Control pins, asynchronous
  input wire logic half_rate_select,
  input wire logic quarter_rate_select,
  input wire logic power_down_in,
  input wire logic gray_format_select,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_out_pkg::ADDR_W-1:0] paddr,
  input wire logic [adc_out_pkg::DATA_W-1:0] pwdata,
  output logic [adc_out_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Output pins with active-low enables
  output logic [adc_out_pkg::WORD_W-1:0] sample_word_bus_a,
  output logic [adc_out_pkg::WORD_W-1:0] sample_word_bus_b,
  output logic range_flag_chan_a,
  output logic range_flag_chan_b,
  output logic word_valid_strobe,
  output logic data_oe_n,
  output logic strobe_oe_n,
  // Interrupt
  output logic irq
);

  logic rst_meta_r;
  logic rst_n_i;
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic pd_s;
  logic gray_s;
  adc_out_pkg::rate_e rate_r;
  adc_out_pkg::rate_e rate_sel;
  logic rate_legal;
  logic rate_chg;
  logic ctrl_en_r;
  logic running;
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic [2:0] phase_last;
  logic strobe_r;
  logic conv_tick;
  logic sample_tick;
  adc_out_pkg::pwr_state_e pwr_st_r;
  logic [3:0] pwr_cnt_r;
  logic oe_n_r;
  logic float_evt;
  logic [adc_out_pkg::NUM_CH-1:0] range_evt;
  logic [adc_out_pkg::WORD_W-1:0] word_q [adc_out_pkg::NUM_CH];
  logic [adc_out_pkg::NUM_CH-1:0] flag_q;
  logic [adc_out_pkg::STATUS_W-1:0] status_r;
  logic [adc_out_pkg::STATUS_W-1:0] status_nxt;
  logic [adc_out_pkg::STATUS_W-1:0] mask_r;
  logic irq_r;
  logic pready_r;
  logic pslverr_r;
  logic [adc_out_pkg::DATA_W-1:0] prdata_r;
  logic apb_setup;
  logic apb_write;
  logic [adc_out_pkg::DATA_W-1:0] rd_mux;
  logic rd_hit;

  coder_if cif ();

  sample_coder u_coder (
    .cif(cif)
  );

  assign cif.raw[0] = raw_sample_a;
  assign cif.raw[1] = raw_sample_b;
  assign cif.gray = gray_s;

  // Reset is released through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_i <= 1'b0;
    end else if (ce) begin
      rst_meta_r <= 1'b1;
      rst_n_i <= rst_meta_r;
    end
  end

  // Pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else if (ce) begin
      pin_meta_r <= {power_down_in, gray_format_select, quarter_rate_select, half_rate_select};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign pd_s = pin_sync_r[adc_out_pkg::PIN_PD];
  assign gray_s = pin_sync_r[adc_out_pkg::PIN_GRAY];

  always_comb begin
    rate_legal = 1'b1;
    unique case ({pin_sync_r[adc_out_pkg::PIN_QUARTER], pin_sync_r[adc_out_pkg::PIN_HALF]})
      2'b00: rate_sel = adc_out_pkg::RATE_FULL;
      2'b01: rate_sel = adc_out_pkg::RATE_HALF;
      2'b10: rate_sel = adc_out_pkg::RATE_QUARTER;
      default: begin
        // Both high is not allowed: keep the running rate and flag it
        rate_sel = rate_r;
        rate_legal = 1'b0;
      end
    endcase
  end

  assign rate_chg = rate_legal && (rate_sel != rate_r);

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_r <= adc_out_pkg::RATE_FULL;
    end else if (ce && rate_legal) begin
      rate_r <= rate_sel;
    end
  end

  assign running = (pwr_st_r == adc_out_pkg::PWR_RUN) && ctrl_en_r;

  // One strobe period is 2 x rate_r clocks, one strobe per divided sample
  assign phase_last = 3'({rate_r, 1'b0} - 4'd1);
  assign phase_nxt = (phase_r == phase_last) ? 3'd0 : phase_r + 3'd1;
  assign conv_tick = running && phase_r[0];
  assign sample_tick = running && (phase_r == phase_last);

  // equal halves whatever the input duty
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= 3'd0;
      strobe_r <= 1'b0;
    end else if (ce) begin
      if (rate_chg) begin
        phase_r <= 3'd0;
        strobe_r <= 1'b0;
      end else if (running) begin
        phase_r <= phase_nxt;
        strobe_r <= (phase_nxt >= rate_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_st_r <= adc_out_pkg::PWR_RUN;
      pwr_cnt_r <= 4'h0;
      oe_n_r <= 1'b0;
    end else if (ce) begin
      unique case (pwr_st_r)
        adc_out_pkg::PWR_RUN: begin
          if (pd_s) begin
            pwr_st_r <= adc_out_pkg::PWR_FLOAT_WAIT;
            pwr_cnt_r <= adc_out_pkg::PD_FLOAT_LOAD;
          end
        end
        adc_out_pkg::PWR_FLOAT_WAIT: begin
          if (!pd_s) begin
            pwr_st_r <= adc_out_pkg::PWR_RUN;
          end else if (pwr_cnt_r == 4'h0) begin
            pwr_st_r <= adc_out_pkg::PWR_FLOAT;
            oe_n_r <= 1'b1;
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 4'h1;
          end
        end
        adc_out_pkg::PWR_FLOAT: begin
          if (!pd_s) begin
            pwr_st_r <= adc_out_pkg::PWR_WAKE_WAIT;
            pwr_cnt_r <= adc_out_pkg::PD_FLOAT_LOAD;
          end
        end
        adc_out_pkg::PWR_WAKE_WAIT: begin
          if (pd_s) begin
            pwr_st_r <= adc_out_pkg::PWR_FLOAT;
          end else if (pwr_cnt_r == 4'h0) begin
            pwr_st_r <= adc_out_pkg::PWR_RUN;
            oe_n_r <= 1'b0;
          end else begin
            pwr_cnt_r <= pwr_cnt_r - 4'h1;
          end
        end
      endcase
    end
  end

  assign float_evt = (pwr_st_r == adc_out_pkg::PWR_FLOAT_WAIT) && pd_s && (pwr_cnt_r == 4'h0);

  for (genvar ch = 0; ch < adc_out_pkg::NUM_CH; ch++) begin : g_ch
    logic [adc_out_pkg::WORD_W:0] pipe_r [adc_out_pkg::PIPE_DEPTH];
    logic [adc_out_pkg::WORD_W-1:0] word_r;
    logic flag_r;

    always_ff @(posedge clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
        for (int i = 0; i < adc_out_pkg::PIPE_DEPTH; i++) begin
          pipe_r[i] <= '0;
        end
      end else if (ce && conv_tick) begin
        for (int i = 1; i < adc_out_pkg::PIPE_DEPTH; i++) begin
          pipe_r[i] <= pipe_r[i-1];
        end
        if (sample_tick) begin
          pipe_r[0] <= {cif.flag[ch], cif.word[ch]};
        end
      end
    end

    // outputs move with the strobe fall
    always_ff @(posedge clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
        word_r <= '0;
        flag_r <= 1'b0;
      end else if (ce && sample_tick) begin
        word_r <= pipe_r[adc_out_pkg::PIPE_DEPTH-1][adc_out_pkg::WORD_W-1:0];
        flag_r <= pipe_r[adc_out_pkg::PIPE_DEPTH-1][adc_out_pkg::WORD_W];
      end
    end

    assign word_q[ch] = word_r;
    assign flag_q[ch] = flag_r;
    assign range_evt[ch] = sample_tick && pipe_r[adc_out_pkg::PIPE_DEPTH-1][adc_out_pkg::WORD_W];
  end

  assign sample_word_bus_a = word_q[0];
  assign sample_word_bus_b = word_q[1];
  assign range_flag_chan_a = flag_q[0];
  assign range_flag_chan_b = flag_q[1];
  assign word_valid_strobe = strobe_r;
  assign data_oe_n = oe_n_r;
  assign strobe_oe_n = oe_n_r;

  // Sticky status: a new event beats a same-cycle clear
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready_r && pwrite;

  always_comb begin
    status_nxt = status_r;
    if (apb_write && (paddr == adc_out_pkg::STATUS_OFS)) begin
      status_nxt = status_r & ~pwdata[adc_out_pkg::STATUS_W-1:0];
    end
    status_nxt = status_nxt | {!rate_legal, float_evt, range_evt};
  end

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_r <= adc_out_pkg::STATUS_RST;
      irq_r <= 1'b0;
    end else if (ce) begin
      status_r <= status_nxt;
      irq_r <= |(status_r & mask_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_en_r <= adc_out_pkg::CTRL_EN_RST;
      mask_r <= adc_out_pkg::MASK_RST;
    end else if (ce && apb_write) begin
      if (paddr == adc_out_pkg::CTRL_OFS) begin
        ctrl_en_r <= pwdata[adc_out_pkg::CTRL_EN_BIT];
      end
      if (paddr == adc_out_pkg::MASK_OFS) begin
        mask_r <= pwdata[adc_out_pkg::STATUS_W-1:0];
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      adc_out_pkg::CTRL_OFS: rd_mux[adc_out_pkg::CTRL_EN_BIT] = ctrl_en_r;
      adc_out_pkg::STATUS_OFS: rd_mux[adc_out_pkg::STATUS_W-1:0] = status_r;
      adc_out_pkg::MASK_OFS: rd_mux[adc_out_pkg::STATUS_W-1:0] = mask_r;
      adc_out_pkg::STATE_OFS: begin
        rd_mux[adc_out_pkg::STATE_PWR_LSB +: 4] = pwr_st_r;
        rd_mux[adc_out_pkg::STATE_RATE_LSB +: 3] = rate_r;
        rd_mux[adc_out_pkg::STATE_GRAY_BIT] = gray_s;
        rd_mux[adc_out_pkg::STATE_FLOAT_BIT] = oe_n_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer in the first access cycle; read data is caught at setup
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (ce) begin
      pready_r <= apb_setup;
      if (apb_setup) begin
        pslverr_r <= !rd_hit;
        prdata_r <= pwrite ? '0 : rd_mux;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_i || !ce);

  logic [3:0] hi_cnt_r;
  logic [3:0] lo_cnt_r;
  logic hi_dirty_r;
  logic lo_dirty_r;
  logic [3:0] primed_r;

  // Counters start dirty so the first strobe half after reset is never judged
  always_ff @(posedge clk) begin
    if (!rst_n_i) begin
      hi_cnt_r <= 4'h0;
      lo_cnt_r <= 4'h0;
      hi_dirty_r <= 1'b1;
      lo_dirty_r <= 1'b1;
    end else if (ce) begin
      hi_cnt_r <= strobe_r ? hi_cnt_r + 4'h1 : 4'h0;
      lo_cnt_r <= strobe_r ? 4'h0 : lo_cnt_r + 4'h1;
      hi_dirty_r <= (rate_chg || !running) ? 1'b1 : (!strobe_r ? 1'b0 : hi_dirty_r);
      lo_dirty_r <= (rate_chg || !running) ? 1'b1 : (strobe_r ? 1'b0 : lo_dirty_r);
    end
    if (!rst_n_i || !ce || rate_chg || !running || rate_r != adc_out_pkg::RATE_FULL) begin
      primed_r <= 4'h0;
    end else if (sample_tick && primed_r != 4'hf) begin
      primed_r <= primed_r + 4'h1;
    end
  end

  sequence s_word_out;
    $fell(strobe_r) && (rate_r == adc_out_pkg::RATE_FULL) && (primed_r >= 4'd9);
  endsequence

  sequence s_pd_held;
    $rose(pd_s) && (pwr_st_r == adc_out_pkg::PWR_RUN) ##1 pd_s;
  endsequence

  sequence s_wake_held;
    $fell(pd_s) && (pwr_st_r == adc_out_pkg::PWR_FLOAT) ##1 !pd_s;
  endsequence

  AST_HIGH_HALF: assert property ($fell(strobe_r) && !hi_dirty_r |-> hi_cnt_r == 4'(rate_r))
    else $error("strobe high time differs from half period");
  AST_LOW_HALF: assert property ($rose(strobe_r) && !lo_dirty_r |-> lo_cnt_r == 4'(rate_r))
    else $error("strobe low time differs from half period");
  AST_WORD_ON_FALL: assert property ($changed(word_q[0]) || $changed(flag_q) |-> $fell(strobe_r))
    else $error("output word changed away from strobe fall");
  AST_LATENCY: assert property (s_word_out |-> word_q[0] == $past(cif.word[0], 17) && flag_q[0] == $past(cif.flag[0], 17))
    else $error("word latency is not eight conversion cycles");
  AST_FLOAT: assert property (s_pd_held |=> oe_n_r)
    else $error("outputs did not float one cycle after power-down");
  AST_WAKE: assert property (s_wake_held |=> !oe_n_r && pwr_st_r == adc_out_pkg::PWR_RUN)
    else $error("outputs not driven one cycle after power-up");
  AST_CLAMP_HI: assert property ($signed(cif.raw[0]) > adc_out_pkg::RAW_MAX && !cif.gray |-> cif.word[0] == adc_out_pkg::FS_POS && cif.flag[0])
    else $error("overrange not clamped and flagged");
  AST_CLAMP_LO: assert property ($signed(cif.raw[1]) < adc_out_pkg::RAW_MIN && cif.gray |-> cif.word[1] == 12'h000 && cif.flag[1])
    else $error("underrange Gray code not zero with flag");
  AST_GRAY_MID: assert property (cif.gray && cif.raw[0] == '0 |-> cif.word[0] == adc_out_pkg::GRAY_MID)
    else $error("Gray midscale code wrong");
  AST_EVT_STICKY: assert property (range_evt[0] |=> status_r[adc_out_pkg::ST_RANGE_A] [*2])
    else $error("range event lost from status");

endmodule

// *** verif/capture_model.sv ***
// Back-end capture logic that latches converter words on the strobe
`timescale 1ns/1ns
module capture_model (
  // Back-end clock
  input wire logic clk,
  // Converter output pins
  input wire logic strobe,
  input wire logic oe_n,
  input wire logic [adc_out_pkg::WORD_W-1:0] word_a,
  input wire logic [adc_out_pkg::WORD_W-1:0] word_b,
  input wire logic flag_a,
  input wire logic flag_b,
  // Captured word pair and counters
  output logic [25:0] cap,
  output int rises,
  output int bad_moves,
  output int clk_miss
);
  logic [25:0] prev_r;
  logic prev_strobe_r;

  initial begin
    cap = '0;
    rises = 0;
    bad_moves = 0;
    clk_miss = 0;
    prev_r = '0;
    prev_strobe_r = 1'b0;
  end

  always @(posedge strobe) begin
    if (oe_n === 1'b0) begin
      cap = {flag_b, word_b, flag_a, word_a};
      rises = rises + 1;
    end
  end

  // moves on fall
  // Pin values seen at a clock edge are those of the cycle before, so no race
  always @(posedge clk) begin
    if (oe_n === 1'b0 && {flag_b, word_b, flag_a, word_a} !== prev_r &&
        !(prev_strobe_r === 1'b1 && strobe === 1'b0)) begin
      bad_moves = bad_moves + 1;
    end
    // clock-edge capture must match the strobe capture
    if (oe_n === 1'b0 && prev_strobe_r === 1'b0 && strobe === 1'b1 &&
        {flag_b, word_b, flag_a, word_a} !== cap) begin
      clk_miss = clk_miss + 1;
    end
    prev_r = {flag_b, word_b, flag_a, word_a};
    prev_strobe_r = strobe;
  end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the converter output block
`timescale 1ns/1ns
module tb_top;
  logic clk, nrst, half_sel, quarter_sel, pd, gray;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] word_a, word_b;
  logic flag_a, flag_b, strobe, data_oe_n, strobe_oe_n, irq;
  logic signed [13:0] raw_a, raw_b;
  logic [25:0] cap;
  int rises, bad_moves, clk_miss, num_errors, n_checks, seed, bm, r0, n, ra, rb;
  int pts[5] = '{2047, 0, -2048, 3000, -3000};

  adc_output_top u_adc_output_top (
    .clk(clk), .nrst(nrst), .ce(1'b1), .raw_sample_a(raw_a), .raw_sample_b(raw_b),
    .half_rate_select(half_sel), .quarter_rate_select(quarter_sel),
    .power_down_in(pd), .gray_format_select(gray), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_word_bus_a(word_a), .sample_word_bus_b(word_b),
    .range_flag_chan_a(flag_a), .range_flag_chan_b(flag_b), .word_valid_strobe(strobe),
    .data_oe_n(data_oe_n), .strobe_oe_n(strobe_oe_n), .irq(irq)
  );

  capture_model u_capture_model (
    .clk(clk), .strobe(strobe), .oe_n(strobe_oe_n), .word_a(word_a), .word_b(word_b),
    .flag_a(flag_a), .flag_b(flag_b), .cap(cap), .rises(rises), .bad_moves(bad_moves),
    .clk_miss(clk_miss)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // Clamp, flag and code a raw sample the way the pins should show it
  function automatic logic [12:0] model(input int raw, input logic g);
    logic [11:0] c;
    logic fl;
    fl = (raw > 2047 || raw < -2048);
    c = raw > 2047 ? 12'h7ff : (raw < -2048 ? 12'h800 : raw[11:0]);
    if (g) begin
      c = c ^ 12'h800;
      c = c ^ (c >> 1);
    end
    return {fl, c};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_sample(input int a, input int b, input logic g);
    raw_a <= 14'(a);
    raw_b <= 14'(b);
    r0 = rises;
    n = 0;
    while (rises < r0 + 12 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check("chan_a", 32'(model(a, g)), 32'(cap[12:0]));
    check("chan_b", 32'(model(b, g)), 32'(cap[25:13]));
  endtask

  task automatic strobe_shape(input int half);
    int hi, lo, k;
    hi = 0;
    lo = 0;
    k = 0;
    // Start from a low phase so a half-seen high phase is not measured
    while (strobe === 1'b1 && k < 50) begin @(posedge clk); k++; end
    while (strobe !== 1'b1 && k < 50) begin @(posedge clk); k++; end
    while (strobe === 1'b1 && k < 50) begin @(posedge clk); hi++; k++; end
    while (strobe === 1'b0 && k < 50) begin @(posedge clk); lo++; k++; end
    check("strobe_high", 32'(half), 32'(hi));
    check("strobe_low", 32'(half), 32'(lo));
  endtask

  // A 10 ns hold means the pins stay driven at least one clock after the pin moves
  task automatic wait_oe(input logic lvl);
    n = 0;
    while (data_oe_n !== lvl && n < 20) begin @(posedge clk); n++; end
    check("oe_delay", 32'h1, 32'(n >= 2 && n <= 6));
    check("strobe_oe", 32'(lvl), 32'(strobe_oe_n));
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  initial begin
    seed = 32'h5c0b8f7f;
    num_errors = 0;
    n_checks = 0;
    {nrst, half_sel, quarter_sel, pd, gray, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    raw_a = '0;
    raw_b = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    apb(1'b0, 12'h000, '0);
    check("ctrl_rst", 32'h1, rd);
    apb(1'b0, 12'h004, '0);
    check("status_rst", 32'h0, rd);
    apb(1'b0, 12'h010, '0);
    check("unmapped_err", 32'h1, 32'(err));
    $display("test registers done");
    for (int g = 0; g < 2; g++) begin
      for (int m = 0; m < 3; m++) begin
        half_sel <= (m == 1);
        quarter_sel <= (m == 2);
        gray <= g[0];
        run_sample(2047, -2048, g[0]);
        bm = bad_moves;
        apb(1'b0, 12'h00c, '0);
        check("rate_state", 32'(1 << m), 32'(rd[6:4]));
        strobe_shape(1 << m);
        for (int k = 0; k < 8; k++) begin
          ra = k < 5 ? pts[k] : $random(seed) % 2300;
          rb = k < 5 ? -pts[k] - 1 : $random(seed) % 2300;
          run_sample(ra, rb, g[0]);
        end
        check("moves_on_fall", 32'(bm), 32'(bad_moves));
        $display("test rate %0d gray %0d done", m, g);
      end
    end
    // Latency is counted in full-rate strobe periods
    quarter_sel <= 1'b0;
    run_sample(100, 100, 1'b1);
    @(posedge strobe);
    @(posedge clk);
    raw_a <= 14'sd3000;
    r0 = rises;
    n = 0;
    while (cap[12:0] !== model(3000, 1'b1) && n < 500) begin @(posedge clk); n++; end
    // One rise before the sample edge, eight latency periods, one capture rise
    check("latency", 32'ha, 32'(rises - r0));
    $display("test latency done");
    half_sel <= 1'b1;
    quarter_sel <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, 12'h00c, '0);
    check("rate_kept", 32'h1, 32'(rd[6:4]));
    apb(1'b0, 12'h004, '0);
    check("bad_div_flag", 32'h9, 32'(rd[3:0] & 4'h9));
    check("irq_masked", 32'h0, 32'(irq));
    half_sel <= 1'b0;
    apb(1'b1, 12'h008, 32'h4);
    pd <= 1'b1;
    wait_oe(1'b1);
    repeat (2) @(posedge clk);
    check("irq_float", 32'h1, 32'(irq));
    apb(1'b1, 12'h004, 32'h4);
    repeat (3) @(posedge clk);
    check("irq_cleared", 32'h0, 32'(irq));
    pd <= 1'b0;
    wait_oe(1'b0);
    run_sample(-5, 5, 1'b1);
    check("clk_capture", 32'h0, 32'(clk_miss));
    $display("test power down done");
    summarize();
  end
endmodule
